// ===== design/tlbtc_map.svh
`ifndef TLBTC_MAP_SVH
`define TLBTC_MAP_SVH
// field widths
`define TLBTC_TAG_W 8
`define TLBTC_VPN_W 20
`define TLBTC_PPN_W 20
`define TLBTC_CMD_W 3
// flush command encodings
`define TLBTC_CMD_NONE 3'h0
`define TLBTC_CMD_ALL 3'h1
`define TLBTC_CMD_TAG 3'h3
`define TLBTC_CMD_TAG_NG 3'h7
// tag used outside any guest context
`define TLBTC_HOST_TAG 8'h00
// defaults
`define TLBTC_ENTRIES 16
`define TLBTC_PERTAG 1'b1
`endif

// ===== design/tlbtc_pkg.sv
`include "tlbtc_map.svh"
package tlbtc_pkg;
  // one translation entry
  typedef struct packed {
    logic valid;
    logic global_pg;
    logic [`TLBTC_TAG_W-1:0] tag;
    logic [`TLBTC_VPN_W-1:0] vpn;
    logic [`TLBTC_PPN_W-1:0] ppn;
  } tlbtc_entry_t;
  // lookup request
  typedef struct packed {
    logic vld;
    logic [`TLBTC_VPN_W-1:0] vpn;
  } tlbtc_lookup_t;
  // fill request, tagged with the current tag
  typedef struct packed {
    logic vld;
    logic global_pg;
    logic [`TLBTC_VPN_W-1:0] vpn;
    logic [`TLBTC_PPN_W-1:0] ppn;
  } tlbtc_fill_t;
  // tagged page invalidate: address from accumulator_reg, tag from count_reg
  typedef struct packed {
    logic vld;
    logic [`TLBTC_VPN_W-1:0] accumulator_reg;
    logic [`TLBTC_TAG_W-1:0] count_reg;
  } tlbtc_inval_t;
  // guest entry op with its flush_command_field
  typedef struct packed {
    logic vld;
    logic [`TLBTC_TAG_W-1:0] tag;
    logic [`TLBTC_CMD_W-1:0] flush_command_field;
  } tlbtc_entry_op_t;
  // paging-control and system events, one-cycle pulses
  typedef struct packed {
    logic page_table_base_wr;
    logic task_switch_base;
    logic paging_on_toggle;
    logic global_pages_on_toggle;
    logic physical_extension_on_toggle;
    logic large_page_on_toggle;
    logic paging_extension_wr;
    logic sys_mgmt_interrupt;
    logic sys_mgmt_return;
    logic memory_type_range_regs_wr;
    logic io_range_regs_wr;
    logic xlat_sys_reg_wr;
  } tlbtc_evt_t;
  // flush kinds decoded from flush_command_field
  typedef enum logic [1:0] {
    TLBTC_FL_NONE = 2'b00,
    TLBTC_FL_ALL = 2'b01,
    TLBTC_FL_TAG = 2'b10,
    TLBTC_FL_TAG_NG = 2'b11
  } tlbtc_flush_t;
endpackage

// ===== design/tlbtc_top.sv
`timescale 1ns/1ps
`include "tlbtc_map.svh"
module tlbtc_top #(
  parameter int ENTRIES = `TLBTC_ENTRIES,
  parameter bit PERTAG = `TLBTC_PERTAG
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire tlbtc_pkg::tlbtc_lookup_t LOOKUP_I,
  input wire tlbtc_pkg::tlbtc_fill_t FILL_I,
  input wire tlbtc_pkg::tlbtc_inval_t INVAL_I,
  input wire tlbtc_pkg::tlbtc_entry_op_t ENTRY_OP_I,
  input wire logic GUEST_EXIT_I,
  input wire tlbtc_pkg::tlbtc_evt_t EVT_I,
  input wire logic INTERCEPT_I,
  output logic HIT_O,
  output logic [`TLBTC_PPN_W-1:0] PPN_O,
  output logic GUEST_EXIT_O,
  output logic CMD_ERROR_O,
  output logic IN_GUEST_O,
  output logic [`TLBTC_TAG_W-1:0] CUR_TAG_O,
  output logic CAP_PERTAG_O
);
  import tlbtc_pkg::*;

  localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    tlbtc_entry_t [ENTRIES-1:0] ent;
    logic [PW-1:0] repl;
    logic in_guest;
    logic [`TLBTC_TAG_W-1:0] cur_tag;
    logic hit;
    logic [`TLBTC_PPN_W-1:0] ppn;
    logic guest_exit;
    logic cmd_error;
    logic cap;
  } tlbtc_state_t;

  tlbtc_state_t st;
  tlbtc_state_t next_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // flush command decode; per-tag codes only when offered
  function automatic tlbtc_flush_t decode_cmd(input logic [`TLBTC_CMD_W-1:0] c,
                                               input logic pertag);
    case (c)
      `TLBTC_CMD_ALL: decode_cmd = TLBTC_FL_ALL;
      `TLBTC_CMD_TAG: decode_cmd = pertag ? TLBTC_FL_TAG : TLBTC_FL_NONE;
      `TLBTC_CMD_TAG_NG: decode_cmd = pertag ? TLBTC_FL_TAG_NG : TLBTC_FL_NONE;
      default: decode_cmd = TLBTC_FL_NONE;
    endcase
  endfunction

  // code outside the supported set
  function automatic logic bad_cmd(input logic [`TLBTC_CMD_W-1:0] c, input logic pertag);
    case (c)
      `TLBTC_CMD_NONE: bad_cmd = 1'b0;
      `TLBTC_CMD_ALL: bad_cmd = 1'b0;
      `TLBTC_CMD_TAG: bad_cmd = !pertag;
      `TLBTC_CMD_TAG_NG: bad_cmd = !pertag;
      default: bad_cmd = 1'b1;
    endcase
  endfunction

  // guest actions that would flush, and thus may be intercepted
  logic guest_flush_act;
  logic intercepted;
  logic sys_flush;
  assign guest_flush_act = EVT_I.page_table_base_wr | EVT_I.task_switch_base
                         | EVT_I.paging_on_toggle | EVT_I.global_pages_on_toggle
                         | EVT_I.physical_extension_on_toggle | EVT_I.large_page_on_toggle
                         | EVT_I.paging_extension_wr;
  assign intercepted = st.in_guest & INTERCEPT_I & guest_flush_act;
  assign sys_flush = EVT_I.sys_mgmt_interrupt | EVT_I.sys_mgmt_return
                   | EVT_I.memory_type_range_regs_wr | EVT_I.io_range_regs_wr
                   | EVT_I.xlat_sys_reg_wr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // order inside a cycle: lookup sees old entries, then flushes, invalidate, fill
  always_comb begin
    logic drop_ng;
    logic drop_tag;
    logic drop_all;
    tlbtc_flush_t op_fl;
    next_st = st;
    drop_ng = 1'b0;
    drop_tag = 1'b0;
    drop_all = 1'b0;
    op_fl = TLBTC_FL_NONE;
    next_st.hit = 1'b0;
    next_st.guest_exit = 1'b0;
    next_st.cmd_error = 1'b0;
    next_st.cap = PERTAG;
    // lookup against the current tag only, global or not
    if (LOOKUP_I.vld) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (st.ent[i].valid && st.ent[i].tag == st.cur_tag
            && st.ent[i].vpn == LOOKUP_I.vpn) begin
          next_st.hit = 1'b1;
          next_st.ppn = st.ent[i].ppn;
        end
      end
    end
    // paging-control flushes scoped to the current tag, unless intercepted
    if (intercepted) begin
      next_st.guest_exit = 1'b1;
      next_st.in_guest = 1'b0;
      next_st.cur_tag = `TLBTC_HOST_TAG;
    end else begin
      drop_ng = EVT_I.page_table_base_wr | EVT_I.task_switch_base;
      drop_tag = EVT_I.paging_extension_wr | EVT_I.paging_on_toggle
               | EVT_I.global_pages_on_toggle | EVT_I.physical_extension_on_toggle
               | EVT_I.large_page_on_toggle;
    end
    drop_all = sys_flush;
    for (int i = 0; i < ENTRIES; i++) begin
      if (drop_all
          || (st.ent[i].tag == st.cur_tag && (drop_tag || (drop_ng && !st.ent[i].global_pg))))
        next_st.ent[i].valid = 1'b0;
    end
    // loads of paging state at entry and exit never flush by themselves
    if (GUEST_EXIT_I && !intercepted) begin
      next_st.in_guest = 1'b0;
      next_st.cur_tag = `TLBTC_HOST_TAG;
    end
    // guest entry: the command is an input, read and never stored or changed
    if (ENTRY_OP_I.vld && !intercepted && !GUEST_EXIT_I) begin
      op_fl = decode_cmd(ENTRY_OP_I.flush_command_field, PERTAG);
      next_st.cmd_error = bad_cmd(ENTRY_OP_I.flush_command_field, PERTAG);
      next_st.in_guest = 1'b1;
      next_st.cur_tag = ENTRY_OP_I.tag;
      for (int i = 0; i < ENTRIES; i++) begin
        case (op_fl)
          TLBTC_FL_ALL: next_st.ent[i].valid = 1'b0;
          TLBTC_FL_TAG: begin
            if (st.ent[i].tag == ENTRY_OP_I.tag)
              next_st.ent[i].valid = 1'b0;
          end
          TLBTC_FL_TAG_NG: begin
            if (st.ent[i].tag == ENTRY_OP_I.tag && !st.ent[i].global_pg)
              next_st.ent[i].valid = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
    // single page under a named tag; global pages of that tag go too
    if (INVAL_I.vld) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (st.ent[i].tag == INVAL_I.count_reg && st.ent[i].vpn == INVAL_I.accumulator_reg)
          next_st.ent[i].valid = 1'b0;
      end
    end
    // fill into the round-robin slot under the tag in force this cycle
    if (FILL_I.vld) begin
      next_st.ent[st.repl].valid = 1'b1;
      next_st.ent[st.repl].global_pg = FILL_I.global_pg;
      next_st.ent[st.repl].tag = st.cur_tag;
      next_st.ent[st.repl].vpn = FILL_I.vpn;
      next_st.ent[st.repl].ppn = FILL_I.ppn;
      next_st.repl = (st.repl == PW'(ENTRIES - 1)) ? '0 : PW'(st.repl + 1'b1);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // reset zeroes the whole state: entries, round-robin slot, guest flag, tag and registered outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      st <= '0;
    else
      st <= next_st;
  end

  assign HIT_O = st.hit;
  assign PPN_O = st.ppn;
  assign GUEST_EXIT_O = st.guest_exit;
  assign CMD_ERROR_O = st.cmd_error;
  assign IN_GUEST_O = st.in_guest;
  assign CUR_TAG_O = st.cur_tag;
  assign CAP_PERTAG_O = st.cap;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [ENTRIES-1:0] vmask;
  logic [ENTRIES-1:0] tag_here;
  logic quiet;
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      vmask[i] = st.ent[i].valid;
      tag_here[i] = st.ent[i].valid && st.ent[i].tag == st.cur_tag;
    end
  end
  assign quiet = !FILL_I.vld && !INVAL_I.vld && !guest_flush_act && !sys_flush;

  reset_clear_a: assert property (@(posedge SYS_CLK_I) RESET_I |=> vmask == '0)
    else $error("entries valid after reset");
  zero_tag_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    !IN_GUEST_O |-> CUR_TAG_O == `TLBTC_HOST_TAG)
    else $error("nonzero tag outside guest");
  exit_intercept_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (intercepted && quiet == 1'b0 && !FILL_I.vld && !INVAL_I.vld && !sys_flush)
    |=> GUEST_EXIT_O && vmask == $past(vmask))
    else $error("intercepted action flushed or no exit");
  full_flush_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (ENTRY_OP_I.vld && ENTRY_OP_I.flush_command_field == `TLBTC_CMD_ALL && !intercepted
     && !GUEST_EXIT_I && !FILL_I.vld) |=> vmask == '0)
    else $error("full flush left entries");
  sysmgmt_flush_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (sys_flush && !FILL_I.vld) |=> vmask == '0)
    else $error("system event left entries");
  foreign_tag_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (LOOKUP_I.vld && tag_here == '0) |=> !HIT_O)
    else $error("hit across tags");
  no_load_flush_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (quiet && (GUEST_EXIT_I || (ENTRY_OP_I.vld
     && ENTRY_OP_I.flush_command_field == `TLBTC_CMD_NONE))) |=> vmask == $past(vmask))
    else $error("state load flushed entries");
  cap_const_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    $past(!RESET_I) |-> CAP_PERTAG_O == PERTAG)
    else $error("capability wrong");
  single_inval_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    (INVAL_I.vld && !FILL_I.vld && !guest_flush_act && !sys_flush && !ENTRY_OP_I.vld)
    |=> $countones(vmask) + 1 >= $countones($past(vmask)))
    else $error("invalidate removed too much");

  hit_c: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) HIT_O && IN_GUEST_O);
  exit_c: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) GUEST_EXIT_O);
  tagfl_c: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    ENTRY_OP_I.vld && ENTRY_OP_I.flush_command_field == `TLBTC_CMD_TAG_NG && vmask != '0);
  err_c: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I) CMD_ERROR_O);
endmodule

// ===== tb/tagged_tlb_flush_control_tb_top.sv
`timescale 1ns/1ps
`include "tlbtc_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module tagged_tlb_flush_control_tb_top;
  import tlbtc_pkg::*;
  // ----------------------------------------
  // stimulus, clock and helpers
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  tlbtc_lookup_t lookup;
  tlbtc_fill_t fill;
  tlbtc_inval_t inval;
  tlbtc_entry_op_t entry_op;
  tlbtc_evt_t evt;
  logic guest_exit;
  logic intercept;
  logic hit, gexit, cmd_err, in_guest, cap;
  logic [19:0] ppn, vn, vg, vh, pa, pb;
  logic [7:0] cur_tag;
  logic [2:0] cmds [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  tlbtc_top DUT (.SYS_CLK_I(sys_clk), .RESET_I(reset), .LOOKUP_I(lookup), .FILL_I(fill),
    .INVAL_I(inval), .ENTRY_OP_I(entry_op), .GUEST_EXIT_I(guest_exit), .EVT_I(evt),
    .INTERCEPT_I(intercept), .HIT_O(hit), .PPN_O(ppn), .GUEST_EXIT_O(gexit),
    .CMD_ERROR_O(cmd_err), .IN_GUEST_O(in_guest), .CUR_TAG_O(cur_tag), .CAP_PERTAG_O(cap));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic idle();
    lookup = '0;
    fill = '0;
    inval = '0;
    entry_op = '0;
    evt = '0;
    guest_exit = 1'b0;
  endtask

  // inputs change at the falling edge only, results read at the next falling edge, one clock later
  task automatic step();
    @(posedge sys_clk);
    @(negedge sys_clk);
    idle();
  endtask

  task automatic do_fill(input logic g, input logic [19:0] v, input logic [19:0] p);
    fill = '{vld: 1'b1, global_pg: g, vpn: v, ppn: p};
    step();
  endtask

  task automatic look(input string nm, input logic [19:0] v, input logic eh,
                      input logic [19:0] ep);
    lookup = '{vld: 1'b1, vpn: v};
    step();
    `CHK(nm, eh, hit)
    if (eh) `CHK(nm, ep, ppn)
  endtask

  task automatic enter(input logic [7:0] t, input logic [2:0] c);
    entry_op = '{vld: 1'b1, tag: t, flush_command_field: c};
    step();
  endtask

  task automatic leave();
    guest_exit = 1'b1;
    step();
    `CHK("host_tag", 8'h00, cur_tag)
    `CHK("left_guest", 1'b0, in_guest)
  endtask

  task automatic pulse(input int idx);
    evt = tlbtc_evt_t'(12'h001 << idx);
    step();
  endtask

  // base register and task switch keep global pages, the rest drop them
  function automatic logic keeps_global(input int idx);
    return idx >= 10;
  endfunction

  function automatic logic keeps_ng(input logic [2:0] c);
    return c == 3'h0 || c == 3'h2;
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    idle();
    intercept = 1'b0;
    void'($urandom(32'hf65d));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    vn = $urandom;
    look("reset_miss", vn, 1'b0, 20'h0);
    `CHK("cap_pertag", 1'b1, cap)
    `CHK("in_guest", 1'b0, in_guest)
    $display("test reset done");
    // host global page must stay invisible to the guest tag
    vn = $urandom; pa = $urandom; pb = $urandom;
    do_fill(1'b1, vn, pa);
    enter(8'h05, 3'h0);
    `CHK("guest_tag", 8'h05, cur_tag)
    `CHK("in_guest_set", 1'b1, in_guest)
    look("glob_other_tag", vn, 1'b0, 20'h0);
    do_fill(1'b0, vn, pb);
    look("guest_hit", vn, 1'b1, pb);
    leave();
    look("host_kept", vn, 1'b1, pa);
    $display("test tags done");
    // paging-control flushes scoped to the current tag
    for (int idx = 11; idx >= 5; idx--) begin
      vn = $urandom; vg = $urandom; pa = $urandom; pb = $urandom;
      do_fill(1'b0, vn, pa);
      do_fill(1'b1, vg, pa);
      enter(8'h05, 3'h0);
      do_fill(1'b0, vn, pb);
      leave();
      pulse(idx);
      look("scoped_ng", vn, 1'b0, 20'h0);
      look("scoped_g", vg, keeps_global(idx), pa);
      enter(8'h05, 3'h0);
      look("other_tag_kept", vn, 1'b1, pb);
      leave();
    end
    $display("test scoped done");
    // system events drop every tag
    for (int idx = 4; idx >= 0; idx--) begin
      vn = $urandom; vg = $urandom; pa = $urandom;
      enter(8'h09, 3'h0);
      do_fill(1'b1, vn, pa);
      leave();
      do_fill(1'b1, vg, pa);
      pulse(idx);
      look("all_host", vg, 1'b0, 20'h0);
      enter(8'h09, 3'h0);
      look("all_guest", vn, 1'b0, 20'h0);
      leave();
    end
    $display("test global done");
    // every command code plus one reserved, as software after table edits would
    foreach (cmds[i]) begin
      vn = $urandom; vg = $urandom; vh = $urandom; pa = $urandom;
      do_fill(1'b1, vh, pa);
      enter(8'h05, 3'h0);
      do_fill(1'b0, vn, pa);
      do_fill(1'b1, vg, pa);
      leave();
      enter(8'h05, cmds[i]);
      `CHK("cmd_error", cmds[i] == 3'h2, cmd_err)
      look("cmd_ng", vn, keeps_ng(cmds[i]), pa);
      look("cmd_g", vg, keeps_ng(cmds[i]) || cmds[i] == 3'h7, pa);
      leave();
      look("cmd_host", vh, cmds[i] != 3'h1, pa);
    end
    $display("test commands done");
    // a retired tag stays unused until a full flush, then may come back
    vn = $urandom; pa = $urandom;
    enter(8'h05, 3'h0);
    do_fill(1'b0, vn, pa);
    leave();
    enter(8'h06, 3'h0);
    look("fresh_tag", vn, 1'b0, 20'h0);
    leave();
    enter(8'h05, 3'h1);
    look("reused_tag", vn, 1'b0, 20'h0);
    leave();
    $display("test retire done");
    // intercepted flush exits the guest and leaves entries alone
    vn = $urandom; pa = $urandom;
    enter(8'h05, 3'h0);
    do_fill(1'b0, vn, pa);
    intercept = 1'b1;
    pulse(11);
    `CHK("exit_pulse", 1'b1, gexit)
    `CHK("exit_tag", 8'h00, cur_tag)
    `CHK("exit_out", 1'b0, in_guest)
    intercept = 1'b0;
    enter(8'h05, 3'h0);
    look("intercept_kept", vn, 1'b1, pa);
    leave();
    // without intercept the guest action flushes its own tag's non-global pages and stays inside
    vn = $urandom; vg = $urandom; pa = $urandom;
    enter(8'h05, 3'h0);
    do_fill(1'b0, vn, pa);
    do_fill(1'b1, vg, pa);
    pulse(11);
    `CHK("no_exit_guest", 1'b0, gexit)
    `CHK("still_guest", 1'b1, in_guest)
    look("guest_ng_gone", vn, 1'b0, 20'h0);
    look("guest_g_kept", vg, 1'b1, pa);
    leave();
    // host actions are never intercepted, so they flush and raise no exit
    vh = $urandom;
    do_fill(1'b0, vh, pa);
    intercept = 1'b1;
    pulse(11);
    `CHK("no_exit_host", 1'b0, gexit)
    intercept = 1'b0;
    look("host_ng_gone", vh, 1'b0, 20'h0);
    $display("test intercept done");
    // invalidate hits only the named tag, global pages included
    vn = $urandom; pa = $urandom;
    do_fill(1'b1, vn, pa);
    inval = '{vld: 1'b1, accumulator_reg: vn, count_reg: 8'h05};
    step();
    look("inval_other", vn, 1'b1, pa);
    inval = '{vld: 1'b1, accumulator_reg: vn, count_reg: 8'h00};
    step();
    look("inval_own", vn, 1'b0, 20'h0);
    $display("test invalidate done");
    // reset in mid-run drops guest state and every entry
    vn = $urandom; pa = $urandom;
    enter(8'h05, 3'h0);
    do_fill(1'b0, vn, pa);
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    `CHK("rst_in_guest", 1'b0, in_guest)
    `CHK("rst_tag", 8'h00, cur_tag)
    enter(8'h05, 3'h0);
    `CHK("rst_cap", 1'b1, cap)
    look("rst_miss", vn, 1'b0, 20'h0);
    leave();
    $display("test mid reset done");
    // random back-to-back fill and lookup
    repeat (20) begin
      vn = $urandom; pa = $urandom;
      do_fill(1'b0, vn, pa);
      look("rand_hit", vn, 1'b1, pa);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule
